// ===== hdl/hscp_pkg.sv
// Constants, states and timing for the humidity sensor command port
package hscp_pkg;
  localparam int          CLK_MHZ     = 100;
  localparam int          WORD_W      = 16;
  localparam int          CNT_W       = 21;
  localparam logic [6:0]  I2C_ADDR    = 7'h70;
  localparam logic [15:0] CMD_SLEEP   = 16'hB098;
  localparam logic [15:0] CMD_WAKE    = 16'h3517;
  localparam logic [15:0] CMD_NT_S    = 16'h7CA2;
  localparam logic [15:0] CMD_NH_S    = 16'h5C24;
  localparam logic [15:0] CMD_LT_S    = 16'h6458;
  localparam logic [15:0] CMD_LH_S    = 16'h44DE;
  localparam logic [15:0] CMD_NT      = 16'h7866;
  localparam logic [15:0] CMD_NH      = 16'h58E0;
  localparam logic [15:0] CMD_LT      = 16'h609C;
  localparam logic [15:0] CMD_LH      = 16'h401A;
  // Mode bits: stretch, low power, humidity first
  localparam logic [2:0]  MODE_NT_S   = 3'h4;
  localparam logic [2:0]  MODE_NH_S   = 3'h5;
  localparam logic [2:0]  MODE_LT_S   = 3'h6;
  localparam logic [2:0]  MODE_LH_S   = 3'h7;
  localparam logic [2:0]  MODE_NT     = 3'h0;
  localparam logic [2:0]  MODE_NH     = 3'h1;
  localparam logic [2:0]  MODE_LT     = 3'h2;
  localparam logic [2:0]  MODE_LH     = 3'h3;
  localparam int          MODE_STR    = 2;
  localparam int          MODE_LP     = 1;
  localparam int          MODE_HF     = 0;
  localparam logic [7:0]  CRC_POLY    = 8'h31;
  localparam logic [7:0]  CRC_INIT    = 8'hFF;
  localparam logic [3:0]  BIT_FULL    = 4'h8;
  localparam logic [3:0]  TX_LAST     = 4'h7;
  localparam logic [2:0]  BYTE_CRC_A  = 3'h2;
  localparam logic [2:0]  BYTE_LAST   = 3'h5;
  localparam int          PU_US       = 240;
  localparam real         CONV_NORM_MS = 12.1;
  localparam real         CONV_LP_MS   = 0.8;
  localparam int          PU_CYC      = PU_US * CLK_MHZ;
  localparam int          CONV_NORM_CYC = $rtoi(CONV_NORM_MS * 1000.0 * CLK_MHZ + 0.001);
  localparam int          CONV_LP_CYC   = $rtoi(CONV_LP_MS * 1000.0 * CLK_MHZ + 0.001);
  typedef enum logic [2:0] {
    PH_IDLE    = 3'b000,
    PH_ADDR    = 3'b001,
    PH_ADACK   = 3'b010,
    PH_WDATA   = 3'b011,
    PH_WDACK   = 3'b100,
    PH_RDATA   = 3'b101,
    PH_RDACK   = 3'b110,
    PH_STRETCH = 3'b111
  } hscp_phase_e;
endpackage : hscp_pkg

// ===== hdl/hscp_cmd_port.sv
// I2C target command port with conversion timing of the humidity sensor
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Standard to fast-plus I2C with clock stretching
// - Answer only target address 0x70
// - Commands are 16-bit, high byte first
// - Idle after power-up delay elapses
// - Asleep, only wakeup command accepted
// - Measurement starts combined temperature humidity conversion
// - Four stretching measurement command codes
// - Four non-stretching codes, order selects first result
// - No stretching: NACK headers while converting
// - Stretching: ACK read, hold SCL until done
// - Send word, CRC, word, CRC after conversion
// - Missing master ACK stops sending, releases bus
// - Conversion at most 12.1 or 0.8 ms
// - CRC-8 poly 0x31, init 0xFF
module hscp_cmd_port #(
  parameter int PU_CYCLES        = hscp_pkg::PU_CYC,
  parameter int CONV_NORM_CYCLES = hscp_pkg::CONV_NORM_CYC,
  parameter int CONV_LP_CYCLES   = hscp_pkg::CONV_LP_CYC
) (
  input  wire logic                        clock,
  input  wire logic                        nrst,
  input  wire logic                        linkClock,
  input  wire logic                        sclIn,
  output logic                             sclOut,
  output logic                             sclOeN,
  input  wire logic                        sdaIn,
  output logic                             sdaOut,
  output logic                             sdaOeN,
  input  wire logic [hscp_pkg::WORD_W-1:0] tempSample,
  input  wire logic [hscp_pkg::WORD_W-1:0] humSample,
  output logic                             measBusy,
  output logic                             deviceReady,
  output logic                             sleeping
);
  import hscp_pkg::*;

  function automatic logic [7:0] hscp_crc8(input logic [15:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : hscp_crc8

  // Main clock domain state
  logic              startS1, startS2, startS3;
  logic [CNT_W-1:0]  puCnt_r;
  logic              ready_r;
  logic              busy_r;
  logic              lpHold_r;
  logic [CNT_W-1:0]  convCnt_r;
  logic [CNT_W-1:0]  convLim;
  logic              doneTog_r;
  logic [WORD_W-1:0] wordA_r, wordB_r;
  logic              startEv;

  // Link clock domain state
  logic              lrstS1, lrstN;
  logic              sclS1, sclS2, sclS3;
  logic              sdaS1, sdaS2, sdaS3;
  logic              readyS1, readyS2;
  logic              doneS1, doneS2, doneS3;
  hscp_phase_e       phase_r;
  logic [3:0]        bitCnt_r;
  logic [7:0]        shift_r;
  logic [7:0]        cmdHi_r;
  logic [2:0]        byteIdx_r;
  logic              rw_r;
  logic              sdaOeN_r, sclOeN_r;
  logic              asleep_r, convActive_r, resValid_r, startTog_r;
  logic [2:0]        mode_r;
  logic              sclRise, sclFall, startCond, stopCond, doneEv;
  logic [15:0]       cmdWord;
  logic              isMeas, cmdOk, cmdExec, ackAddr, rdStart;
  logic [2:0]        cmdMode;
  logic [2:0]        txIdx;
  logic [7:0]        txByte;

  // Main clock domain
  always_ff @(posedge clock) begin
    if (!nrst) begin
      startS1 <= 1'b0;
      startS2 <= 1'b0;
      startS3 <= 1'b0;
    end else begin
      startS1 <= startTog_r;
      startS2 <= startS1;
      startS3 <= startS2;
    end
  end
  assign startEv = startS2 ^ startS3;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      puCnt_r <= '0;
      ready_r <= 1'b0;
    end else if (!ready_r) begin
      if (puCnt_r == CNT_W'(PU_CYCLES - 1)) begin
        ready_r <= 1'b1;
      end
      puCnt_r <= puCnt_r + CNT_W'(1);
    end
  end

  assign convLim = lpHold_r ? CNT_W'(CONV_LP_CYCLES - 1) : CNT_W'(CONV_NORM_CYCLES - 1);

  // Mode bits are held by the link side while its start toggle is in flight
  always_ff @(posedge clock) begin
    if (!nrst) begin
      busy_r    <= 1'b0;
      lpHold_r  <= 1'b0;
      convCnt_r <= '0;
      doneTog_r <= 1'b0;
      wordA_r   <= '0;
      wordB_r   <= '0;
    end else if (!busy_r) begin
      if (startEv) begin
        busy_r    <= 1'b1;
        lpHold_r  <= mode_r[MODE_LP];
        convCnt_r <= '0;
      end
    end else if (convCnt_r == convLim) begin
      busy_r    <= 1'b0;
      doneTog_r <= ~doneTog_r;
      wordA_r   <= mode_r[MODE_HF] ? humSample : tempSample;
      wordB_r   <= mode_r[MODE_HF] ? tempSample : humSample;
    end else begin
      convCnt_r <= convCnt_r + CNT_W'(1);
    end
  end

  assign measBusy    = busy_r;
  assign deviceReady = ready_r;

  // Link clock domain
  always_ff @(posedge linkClock) begin
    lrstS1 <= nrst;
    lrstN  <= lrstS1;
  end

  always_ff @(posedge linkClock) begin
    if (!lrstN) begin
      sclS1   <= 1'b1;
      sclS2   <= 1'b1;
      sclS3   <= 1'b1;
      sdaS1   <= 1'b1;
      sdaS2   <= 1'b1;
      sdaS3   <= 1'b1;
      readyS1 <= 1'b0;
      readyS2 <= 1'b0;
      doneS1  <= 1'b0;
      doneS2  <= 1'b0;
      doneS3  <= 1'b0;
    end else begin
      sclS1   <= sclIn;
      sclS2   <= sclS1;
      sclS3   <= sclS2;
      sdaS1   <= sdaIn;
      sdaS2   <= sdaS1;
      sdaS3   <= sdaS2;
      readyS1 <= ready_r;
      readyS2 <= readyS1;
      doneS1  <= doneTog_r;
      doneS2  <= doneS1;
      doneS3  <= doneS2;
    end
  end

  assign sclRise   = sclS2 & ~sclS3;
  assign sclFall   = ~sclS2 & sclS3;
  assign startCond = sclS2 & sclS3 & sdaS3 & ~sdaS2;
  assign stopCond  = sclS2 & sclS3 & ~sdaS3 & sdaS2;
  assign doneEv    = doneS2 ^ doneS3;

  assign cmdWord = {cmdHi_r, shift_r};

  always_comb begin
    isMeas  = 1'b1;
    cmdMode = MODE_NT;
    case (cmdWord)
      CMD_NT_S: cmdMode = MODE_NT_S;
      CMD_NH_S: cmdMode = MODE_NH_S;
      CMD_LT_S: cmdMode = MODE_LT_S;
      CMD_LH_S: cmdMode = MODE_LH_S;
      CMD_NT:   cmdMode = MODE_NT;
      CMD_NH:   cmdMode = MODE_NH;
      CMD_LT:   cmdMode = MODE_LT;
      CMD_LH:   cmdMode = MODE_LH;
      default:  isMeas  = 1'b0;
    endcase
  end

  assign cmdOk = asleep_r ? (cmdWord == CMD_WAKE) :
                 (isMeas | cmdWord == CMD_SLEEP | cmdWord == CMD_WAKE);
  assign cmdExec = phase_r == PH_WDATA && sclFall && bitCnt_r == BIT_FULL && byteIdx_r == 3'h1 && cmdOk;

  // Header acknowledge policy
  assign ackAddr = shift_r[7:1] == I2C_ADDR && readyS2 &&
                   (shift_r[0] ? (resValid_r | (convActive_r & mode_r[MODE_STR]))
                               : ~convActive_r);
  assign rdStart = (phase_r == PH_ADACK && sclFall && rw_r && resValid_r) ||
                   (phase_r == PH_STRETCH && resValid_r && !startCond && !stopCond);

  assign txIdx = (phase_r == PH_RDACK) ? byteIdx_r + 3'h1 : 3'h0;

  always_comb begin
    case (txIdx)
      3'h0:    txByte = wordA_r[15:8];
      3'h1:    txByte = wordA_r[7:0];
      3'h2:    txByte = hscp_crc8(wordA_r);
      3'h3:    txByte = wordB_r[15:8];
      3'h4:    txByte = wordB_r[7:0];
      default: txByte = hscp_crc8(wordB_r);
    endcase
  end

  // Command and conversion bookkeeping
  always_ff @(posedge linkClock) begin
    if (!lrstN) begin
      asleep_r     <= 1'b0;
      startTog_r   <= 1'b0;
      mode_r       <= MODE_NT;
      convActive_r <= 1'b0;
      resValid_r   <= 1'b0;
    end else begin
      if (cmdExec) begin
        if (isMeas) begin
          startTog_r   <= ~startTog_r;
          mode_r       <= cmdMode;
          convActive_r <= 1'b1;
          resValid_r   <= 1'b0;
        end else begin
          asleep_r <= cmdWord == CMD_SLEEP;
        end
      end else if (rdStart) begin
        resValid_r <= 1'b0;
      end
      if (doneEv) begin
        convActive_r <= 1'b0;
        resValid_r   <= 1'b1;
      end
    end
  end

  // Bit and byte engine
  always_ff @(posedge linkClock) begin
    if (!lrstN) begin
      phase_r   <= PH_IDLE;
      bitCnt_r  <= 4'h0;
      shift_r   <= 8'h00;
      cmdHi_r   <= 8'h00;
      byteIdx_r <= 3'h0;
      rw_r      <= 1'b0;
      sdaOeN_r  <= 1'b1;
      sclOeN_r  <= 1'b1;
    end else if (startCond) begin
      phase_r  <= PH_ADDR;
      bitCnt_r <= 4'h0;
      sdaOeN_r <= 1'b1;
      sclOeN_r <= 1'b1;
    end else if (stopCond) begin
      phase_r  <= PH_IDLE;
      sdaOeN_r <= 1'b1;
      sclOeN_r <= 1'b1;
    end else begin
      case (phase_r)
        PH_ADDR, PH_WDATA: begin
          if (sclRise) begin
            shift_r  <= {shift_r[6:0], sdaS2};
            bitCnt_r <= bitCnt_r + 4'h1;
          end else if (sclFall && bitCnt_r == BIT_FULL) begin
            bitCnt_r <= 4'h0;
            if (phase_r == PH_ADDR) begin
              rw_r      <= shift_r[0];
              byteIdx_r <= 3'h0;
              if (ackAddr) begin
                phase_r  <= PH_ADACK;
                sdaOeN_r <= 1'b0;
              end else begin
                phase_r <= PH_IDLE;
              end
            end else if (byteIdx_r == 3'h0) begin
              cmdHi_r   <= shift_r;
              byteIdx_r <= 3'h1;
              phase_r   <= PH_WDACK;
              sdaOeN_r  <= 1'b0;
            end else if (byteIdx_r == 3'h1 && cmdOk) begin
              byteIdx_r <= 3'h2;
              phase_r   <= PH_WDACK;
              sdaOeN_r  <= 1'b0;
            end else begin
              phase_r <= PH_IDLE;
            end
          end
        end
        PH_ADACK: begin
          if (sclFall) begin
            sdaOeN_r <= 1'b1;
            if (!rw_r) begin
              phase_r <= PH_WDATA;
            end else if (resValid_r) begin
              shift_r  <= txByte;
              sdaOeN_r <= txByte[7];
              phase_r  <= PH_RDATA;
            end else begin
              sclOeN_r <= 1'b0;
              phase_r  <= PH_STRETCH;
            end
          end
        end
        PH_WDACK: begin
          if (sclFall) begin
            sdaOeN_r <= 1'b1;
            phase_r  <= PH_WDATA;
          end
        end
        PH_STRETCH: begin
          if (resValid_r) begin
            shift_r  <= txByte;
            sdaOeN_r <= txByte[7];
            phase_r  <= PH_RDATA;
          end
        end
        PH_RDATA: begin
          // SCL released one cycle after the first bit is set up
          sclOeN_r <= 1'b1;
          if (sclFall) begin
            if (bitCnt_r == TX_LAST) begin
              bitCnt_r <= 4'h0;
              sdaOeN_r <= 1'b1;
              phase_r  <= PH_RDACK;
            end else begin
              bitCnt_r <= bitCnt_r + 4'h1;
              shift_r  <= {shift_r[6:0], 1'b0};
              sdaOeN_r <= shift_r[6];
            end
          end
        end
        PH_RDACK: begin
          if (sclRise && sdaS2) begin
            phase_r <= PH_IDLE;
          end else if (sclFall) begin
            if (byteIdx_r == BYTE_LAST) begin
              phase_r <= PH_IDLE;
            end else begin
              byteIdx_r <= byteIdx_r + 3'h1;
              shift_r   <= txByte;
              sdaOeN_r  <= txByte[7];
              phase_r   <= PH_RDATA;
            end
          end
        end
        default: begin
          phase_r <= PH_IDLE;
        end
      endcase
    end
  end

  // Open-drain pins only ever pull low
  assign sdaOut   = 1'b0;
  assign sclOut   = 1'b0;
  assign sdaOeN   = sdaOeN_r;
  assign sclOeN   = sclOeN_r;
  assign sleeping = asleep_r;

  // Checks
  a_addr_only: assert property (@(posedge linkClock) disable iff (!lrstN)
    (phase_r == PH_ADDR && sclFall && bitCnt_r == BIT_FULL && shift_r[7:1] != I2C_ADDR)
    |=> phase_r == PH_IDLE && sdaOeN_r) else $error("foreign address acknowledged");
  a_nack_busy: assert property (@(posedge linkClock) disable iff (!lrstN)
    (phase_r == PH_ADDR && sclFall && bitCnt_r == BIT_FULL && convActive_r && !mode_r[MODE_STR])
    |=> sdaOeN_r && phase_r == PH_IDLE) else $error("header acknowledged during conversion");
  a_stretch_hold: assert property (@(posedge linkClock) disable iff (!lrstN)
    $fell(sclOeN_r) |-> phase_r == PH_STRETCH && $past(convActive_r) && mode_r[MODE_STR])
    else $error("scl held without stretching conversion");
  a_nack_release: assert property (@(posedge linkClock) disable iff (!lrstN)
    (phase_r == PH_RDACK && sclRise && sdaS2 && !startCond && !stopCond)
    |=> phase_r == PH_IDLE ##1 sdaOeN_r) else $error("sending continued after nack");
  a_sleep_wake: assert property (@(posedge linkClock) disable iff (!lrstN)
    (asleep_r && cmdExec) |-> cmdWord == CMD_WAKE ##1 !asleep_r)
    else $error("command other than wakeup taken while asleep");
  a_meas_start: assert property (@(posedge linkClock) disable iff (!lrstN)
    (cmdExec && isMeas) |=> startTog_r != $past(startTog_r) && convActive_r && !resValid_r)
    else $error("measurement command did not start conversion");
  a_stop_idle: assert property (@(posedge linkClock) disable iff (!lrstN)
    stopCond |=> phase_r == PH_IDLE && sdaOeN_r && sclOeN_r) else $error("stop did not release bus");
  a_crc_byte: assert property (@(posedge linkClock) disable iff (!lrstN)
    (phase_r == PH_RDACK && sclFall && byteIdx_r == BYTE_CRC_A - 3'h1 && !startCond)
    |=> shift_r == hscp_crc8(wordA_r)) else $error("wrong crc byte loaded");
  a_conv_time: assert property (@(posedge clock) disable iff (!nrst)
    busy_r |-> convCnt_r <= convLim) else $error("conversion overran its duration");
  a_power_up: assert property (@(posedge clock) disable iff (!nrst)
    $rose(ready_r) |-> $past(puCnt_r) == CNT_W'(PU_CYCLES - 1)) else $error("idle entered at wrong time");

  c_stretch_read: cover property (@(posedge linkClock) disable iff (!lrstN)
    phase_r == PH_STRETCH ##1 phase_r == PH_RDATA);
  c_full_read: cover property (@(posedge linkClock) disable iff (!lrstN)
    phase_r == PH_RDACK && byteIdx_r == BYTE_LAST && sclFall);
  c_sleep_cmd: cover property (@(posedge linkClock) disable iff (!lrstN)
    cmdExec && cmdWord == CMD_SLEEP);
  c_early_nack: cover property (@(posedge linkClock) disable iff (!lrstN)
    phase_r == PH_RDACK && sclRise && sdaS2 && byteIdx_r == 3'h1);
endmodule : hscp_cmd_port
`default_nettype wire

// ===== verif/hscp_i2c_master.sv
// I2C bus master model driving the command port from the far side
`timescale 1ns/1ns
`default_nettype none
module hscp_i2c_master (
  input  wire logic clock,
  input  wire logic scl,
  input  wire logic sda,
  output logic      sclOeN,
  output logic      sdaOeN,
  output logic      stuck
);
  localparam int HALF = 50;
  localparam int SET  = 30;
  initial begin
    sclOeN = 1'b1;
    sdaOeN = 1'b1;
    stuck  = 1'b0;
  end
  // One SCL period of 1 us; a held-low SCL is waited out, bounded
  task automatic bit_io(input logic b, output logic r);
    int n;
    repeat (5) @(negedge clock);
    sdaOeN = b;
    repeat (HALF - 5) @(negedge clock);
    sclOeN = 1'b1;
    n = 0;
    while (scl !== 1'b1 && n < 9000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 9000) stuck = 1'b1;
    repeat (HALF) @(negedge clock);
    r = sda;
    sclOeN = 1'b0;
  endtask : bit_io
  task automatic start();
    sdaOeN = 1'b1;
    repeat (SET) @(negedge clock);
    sclOeN = 1'b1;
    repeat (SET) @(negedge clock);
    sdaOeN = 1'b0;
    repeat (SET) @(negedge clock);
    sclOeN = 1'b0;
  endtask : start
  task automatic stop();
    repeat (5) @(negedge clock);
    sdaOeN = 1'b0;
    repeat (SET) @(negedge clock);
    sclOeN = 1'b1;
    repeat (SET) @(negedge clock);
    sdaOeN = 1'b1;
    repeat (SET) @(negedge clock);
  endtask : stop
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wr_byte
  task automatic rd_byte(input logic ackIt, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~ackIt, r);
  endtask : rd_byte
endmodule : hscp_i2c_master
`default_nettype wire

// ===== verif/hscp_cmd_port_tb_top.sv
// Self-checking testbench of the humidity sensor command port
`timescale 1ns/1ns
`default_nettype none
module hscp_cmd_port_tb_top;
  import hscp_pkg::*;
  localparam int          PU = 20;
  localparam int          CN = 2000;
  localparam int          CL = 1500;
  localparam logic [15:0] CMDS [8]  = '{CMD_NT_S, CMD_NH_S, CMD_LT_S, CMD_LH_S, CMD_NT, CMD_NH, CMD_LT, CMD_LH};
  localparam logic [2:0]  MODES [8] = '{MODE_NT_S, MODE_NH_S, MODE_LT_S, MODE_LH_S, MODE_NT, MODE_NH, MODE_LT, MODE_LH};
  localparam logic [6:0]  BAD [3]   = '{7'h71, 7'h30, 7'h78};
  logic        clock, nrst, linkClock;
  logic        sclOut, sclOeN, sdaOut, sdaOeN, mSclOeN, mSdaOeN, stuck;
  logic        measBusy, deviceReady, sleeping;
  logic [15:0] tempSample, humSample, seed;
  logic [7:0]  rx [6];
  int          mismatches = 0;
  int          n_checks = 0;
  int          busyCnt = 0;
  int          busyLen = 0;
  int          strCnt = 0;
  wire logic   scl;
  wire logic   sda;
  // Open-drain wires with pull-ups
  assign scl = mSclOeN & (sclOeN | sclOut);
  assign sda = mSdaOeN & (sdaOeN | sdaOut);
  initial clock = 1'b0;
  always #5 clock = ~clock;
  initial linkClock = 1'b0;
  always #3 linkClock = ~linkClock;
  hscp_cmd_port #(.PU_CYCLES(PU), .CONV_NORM_CYCLES(CN), .CONV_LP_CYCLES(CL)) DUT (
    .clock       (clock),
    .nrst        (nrst),
    .linkClock   (linkClock),
    .sclIn       (scl),
    .sclOut      (sclOut),
    .sclOeN      (sclOeN),
    .sdaIn       (sda),
    .sdaOut      (sdaOut),
    .sdaOeN      (sdaOeN),
    .tempSample  (tempSample),
    .humSample   (humSample),
    .measBusy    (measBusy),
    .deviceReady (deviceReady),
    .sleeping    (sleeping)
  );
  hscp_i2c_master m (
    .clock  (clock),
    .scl    (scl),
    .sda    (sda),
    .sclOeN (mSclOeN),
    .sdaOeN (mSdaOeN),
    .stuck  (stuck)
  );
  // Conversion length and stretch observation
  always @(posedge clock) begin
    if (measBusy === 1'b1) busyCnt <= busyCnt + 1;
    else if (busyCnt != 0) begin
      busyLen <= busyCnt;
      busyCnt <= 0;
    end
    if (measBusy === 1'b1 && sclOeN === 1'b0) strCnt <= strCnt + 1;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction : crc8
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task automatic send_cmd(input logic [15:0] c, output logic [2:0] a);
    m.start();
    m.wr_byte({I2C_ADDR, 1'b0}, a[2]);
    m.wr_byte(c[15:8], a[1]);
    m.wr_byte(c[7:0], a[0]);
    m.stop();
  endtask : send_cmd
  task automatic read_res(input int nb, output logic a);
    m.start();
    m.wr_byte({I2C_ADDR, 1'b1}, a);
    if (a === 1'b1) for (int k = 0; k < nb; k++) m.rd_byte(k < nb - 1, rx[k]);
    m.stop();
  endtask : read_res
  initial begin : main
    logic [2:0]  a;
    logic [2:0]  md;
    logic        h;
    logic [15:0] wa;
    logic [15:0] wb;
    logic [7:0]  ex [6];
    int          nb;
    int          t;
    int          s0;
    nrst = 1'b0;
    tempSample = 16'h0000;
    humSample = 16'h0000;
    seed = 16'h0041;
    repeat (4) @(negedge clock);
    nrst = 1'b1;
    repeat (PU - 2) @(negedge clock);
    check("rdy_early", deviceReady, 1'b0);
    repeat (4) @(negedge clock);
    check("rdy_late", deviceReady, 1'b1);
    check("crc_ref", crc8(16'hBEEF), 8'h92);
    foreach (BAD[j]) begin
      m.start();
      m.wr_byte({BAD[j], 1'b0}, h);
      m.stop();
      check("bad_addr", h, 1'b0);
    end
    send_cmd(16'hA27C, a);
    check("swap_cmd", a, 3'b110);
    send_cmd(CMD_SLEEP, a);
    check("sleep_ack", a, 3'b111);
    check("asleep", sleeping, 1'b1);
    send_cmd(CMD_NT, a);
    check("cmd_asleep", a, 3'b110);
    check("no_conv", measBusy, 1'b0);
    send_cmd(CMD_WAKE, a);
    check("wake_ack", a, 3'b111);
    check("awake", sleeping, 1'b0);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      tempSample = seed;
      seed = lfsr(seed);
      humSample = seed;
      md = MODES[i];
      nb = i[0] ? (i == 1 ? 5 : int'(seed[2:0]) % 5 + 1) : 6;
      s0 = strCnt;
      send_cmd(CMDS[i], a);
      check("meas_ack", a, 3'b111);
      check("busy", measBusy, 1'b1);
      read_res(nb, h);
      check("hdr_early", h, md[MODE_STR]);
      t = 0;
      while (h !== 1'b1 && t < 10) begin
        read_res(nb, h);
        t++;
      end
      check("stretch", strCnt != s0, md[MODE_STR]);
      wa = md[MODE_HF] ? humSample : tempSample;
      wb = md[MODE_HF] ? tempSample : humSample;
      ex = '{wa[15:8], wa[7:0], crc8(wa), wb[15:8], wb[7:0], crc8(wb)};
      for (int k = 0; k < nb; k++) check("rx_byte", rx[k], ex[k]);
      check("sda_free", sdaOeN, 1'b1);
      check("scl_free", sclOeN, 1'b1);
      check("conv_len", busyLen, md[MODE_LP] ? CL : CN);
      if (nb < 6) begin
        read_res(1, h);
        check("reread", h, 1'b0);
      end
    end
    send_cmd(CMD_SLEEP, a);
    check("end_sleep", a, 3'b111);
    check("stuck", stuck, 1'b0);
    give_verdict();
  end
  initial begin : watchdog
    repeat (120000) @(posedge clock);
    mismatches++;
    give_verdict();
  end
endmodule : hscp_cmd_port_tb_top
`default_nettype wire
